/* inc/mcr_pkg.sv */
package mcr_pkg;

  // Clock and link rates, in kHz
  localparam int CLK_KHZ = 250000;
  localparam int RATE_1G_KHZ = 125000;
  localparam int RATE_100_KHZ = 25000;
  localparam int RATE_10_KHZ = 2500;
  localparam int DIV_1G = CLK_KHZ / RATE_1G_KHZ;
  localparam int DIV_100 = CLK_KHZ / RATE_100_KHZ;
  localparam int DIV_10 = CLK_KHZ / RATE_10_KHZ;
  localparam int DIV_W = 7;

  // Address widths with and without the timestamping endpoint
  localparam int ADDR_W_TS = 17;
  localparam int ADDR_W_PLAIN = 12;

  // Configuration vector widths
  localparam int RX_VEC_W = 80;
  localparam int TX_VEC_W = 80;
  localparam int RX_VEC_W_PFC = 96;
  localparam int TX_VEC_W_PFC = 368;

  // Speed field positions
  localparam int SPD_REG_LSB = 30;
  localparam int SPD_VEC_LSB = 65;

  // Speed encodings
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1G = 2'h2;

  // Register byte offsets
  localparam logic [16:0] OFS_RX_CFG = 17'h00000;
  localparam logic [16:0] OFS_TX_CFG = 17'h00004;
  localparam logic [16:0] OFS_SPEED = 17'h00008;
  localparam logic [16:0] OFS_STATUS = 17'h0000C;
  localparam logic [16:0] OFS_PHY_MGMT = 17'h00010;

  // Reset values
  localparam logic [31:0] RST_RX_CFG = 32'h00000000;
  localparam logic [31:0] RST_TX_CFG = 32'h00000000;
  localparam logic [31:0] RST_SPEED = 32'h80000000;
  localparam logic [31:0] RST_PHY_MGMT = 32'h00000000;

  // Self-clearing software reset bit in the RX and TX config registers
  localparam int SWRST_BIT = 31;
  localparam int SWRST_CYCLES = 16;
  localparam int SWRST_W = 5;

  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    REG_NONE = 3'h0,
    REG_RX = 3'h1,
    REG_TX = 3'h2,
    REG_SPD = 3'h3,
    REG_STAT = 3'h4,
    REG_PHY = 3'h5
  } mcr_reg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ANSWER = 2'b10
  } mcr_bus_state_t;

  typedef struct packed {
    logic hundred;
    logic low;
  } mcr_speed_flags_t;

endpackage : mcr_pkg

/* rtl/mcr_rate_div.sv */
`timescale 1ns/1ps
module mcr_rate_div
  import mcr_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic hold, // Domain held in reset
  input wire logic [1:0] speed, // Speed code
  output logic tick // One pulse per link clock period
);

  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] limit;

  always_comb begin
    case (speed)
      SPD_100: limit = DIV_W'(DIV_100 - 1);
      SPD_10: limit = DIV_W'(DIV_10 - 1);
      default: limit = DIV_W'(DIV_1G - 1);
    endcase
  end

  // A speed change restarts cleanly because the compare is >=
  always_ff @(posedge clock) begin
    if (rst || hold) begin
      count <= '0;
      tick <= 1'b0;
    end else if (count >= limit) begin
      count <= '0;
      tick <= 1'b1;
    end else begin
      count <= count + DIV_W'(1);
      tick <= 1'b0;
    end
  end

endmodule : mcr_rate_div

/* rtl/mcr_top.sv */
`timescale 1ns/1ps
module mcr_top
  import mcr_pkg::*;
#(
  parameter bit MGMT_EN = 1'b1,
  parameter bit TS_EN = 1'b0,
  parameter bit PFC_EN = 1'b0,
  parameter int ADDR_W = TS_EN ? ADDR_W_TS : ADDR_W_PLAIN,
  parameter int RXV_W = PFC_EN ? RX_VEC_W_PFC : RX_VEC_W,
  parameter int TXV_W = PFC_EN ? TX_VEC_W_PFC : TX_VEC_W
)(
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic glbl_rst_n, // Global reset pin
  input wire logic rx_dom_rst_n, // RX domain reset pin
  input wire logic tx_dom_rst_n, // TX domain reset pin
  input wire logic [ADDR_W-1:0] address, // Avalon byte address
  input wire logic read, // Avalon read
  input wire logic write, // Avalon write
  input wire logic [31:0] writedata, // Avalon write data
  input wire logic [3:0] byteenable, // Avalon byte lanes
  output logic [31:0] readdata, // Avalon read data
  output logic [1:0] response, // Avalon response
  output logic waitrequest, // Avalon wait
  input wire logic [RXV_W-1:0] rx_cfg_vec, // RX config vector
  input wire logic [TXV_W-1:0] tx_cfg_vec, // TX config vector
  output logic [RXV_W-1:0] rx_cfg_eff, // Settings in force, RX
  output logic [TXV_W-1:0] tx_cfg_eff, // Settings in force, TX
  output logic [31:0] phy_mgmt_word, // PHY management word
  output logic phy_mgmt_go, // PHY management request pulse
  output logic rx_reset, // RX reset indication
  output logic tx_reset, // TX reset indication
  output logic tx_clk_en, // TX link clock enable
  output logic rx_clk_en, // RX link clock enable
  output mcr_speed_flags_t speed_flags // Hundred and low flags
);

  function automatic mcr_speed_flags_t speed_decode(input logic [1:0] spd);
    mcr_speed_flags_t f;
    f.hundred = (spd == SPD_100);
    f.low = (spd == SPD_100) || (spd == SPD_10);
    return f;
  endfunction : speed_decode

  function automatic mcr_reg_t reg_decode(input logic [ADDR_W-1:0] a);
    logic [16:0] wide;
    wide = 17'(a);
    case (wide)
      OFS_RX_CFG: return REG_RX;
      OFS_TX_CFG: return REG_TX;
      OFS_SPEED: return REG_SPD;
      OFS_STATUS: return REG_STAT;
      OFS_PHY_MGMT: return REG_PHY;
      default: return REG_NONE;
    endcase
  endfunction : reg_decode

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  // Global reset pin: asserted at once, released through two flops
  logic glbl_meta;
  logic glbl_hold;
  always_ff @(posedge clock or negedge glbl_rst_n) begin
    if (!glbl_rst_n) begin
      glbl_meta <= 1'b1;
      glbl_hold <= 1'b1;
    end else begin
      glbl_meta <= 1'b0;
      glbl_hold <= glbl_meta;
    end
  end

  // Pin release is synced, so core state leaves reset on a clean edge
  logic core_rst;
  assign core_rst = rst || glbl_hold;

  logic [1:0] rx_pin_sync;
  logic [1:0] tx_pin_sync;
  always_ff @(posedge clock) begin
    rx_pin_sync <= {rx_pin_sync[0], rx_dom_rst_n};
    tx_pin_sync <= {tx_pin_sync[0], tx_dom_rst_n};
  end

  // Vector entry registers; second stage alone feeds logic
  logic [RXV_W-1:0] rx_vec_meta;
  logic [RXV_W-1:0] rx_vec_s;
  logic [TXV_W-1:0] tx_vec_meta;
  logic [TXV_W-1:0] tx_vec_s;
  always_ff @(posedge clock) begin
    rx_vec_meta <= rx_cfg_vec;
    rx_vec_s <= rx_vec_meta;
    tx_vec_meta <= tx_cfg_vec;
    tx_vec_s <= tx_vec_meta;
  end

  // Register file
  logic [31:0] rx_cfg;
  logic [31:0] tx_cfg;
  logic [31:0] speed_cfg;
  mcr_bus_state_t state;
  mcr_reg_t sel;
  logic take_wr;
  logic [SWRST_W-1:0] rx_sw_count;
  logic [SWRST_W-1:0] tx_sw_count;

  assign sel = reg_decode(address);
  // Writes land at the edge that ends the wait, the master's sampling edge
  assign take_wr = write && (state == ST_ANSWER) && MGMT_EN;

  always_ff @(posedge clock) begin
    if (core_rst) begin
      rx_cfg <= RST_RX_CFG;
      tx_cfg <= RST_TX_CFG;
      speed_cfg <= RST_SPEED;
      phy_mgmt_word <= RST_PHY_MGMT;
      phy_mgmt_go <= 1'b0;
    end else begin
      phy_mgmt_go <= 1'b0;
      if (take_wr) begin
        case (sel)
          REG_RX: rx_cfg <= lane_merge(rx_cfg, writedata, byteenable);
          REG_TX: tx_cfg <= lane_merge(tx_cfg, writedata, byteenable);
          REG_SPD: speed_cfg <= lane_merge(speed_cfg, writedata, byteenable);
          REG_PHY: begin
            phy_mgmt_word <= lane_merge(phy_mgmt_word, writedata, byteenable);
            phy_mgmt_go <= 1'b1;
          end
          default: ;
        endcase
      end
      // Software reset bits clear themselves once taken
      if (rx_cfg[SWRST_BIT]) begin
        rx_cfg[SWRST_BIT] <= 1'b0;
      end
      if (tx_cfg[SWRST_BIT]) begin
        tx_cfg[SWRST_BIT] <= 1'b0;
      end
    end
  end

  // Software reset stretchers
  // A repeat write restarts the count; the hold stays continuous
  always_ff @(posedge clock) begin
    if (core_rst) begin
      rx_sw_count <= '0;
      tx_sw_count <= '0;
    end else begin
      if (rx_cfg[SWRST_BIT]) begin
        rx_sw_count <= SWRST_W'(SWRST_CYCLES);
      end else if (rx_sw_count != '0) begin
        rx_sw_count <= rx_sw_count - SWRST_W'(1);
      end
      if (tx_cfg[SWRST_BIT]) begin
        tx_sw_count <= SWRST_W'(SWRST_CYCLES);
      end else if (tx_sw_count != '0) begin
        tx_sw_count <= tx_sw_count - SWRST_W'(1);
      end
    end
  end

  logic rx_hold;
  logic tx_hold;
  assign rx_hold = !rx_pin_sync[1] || (rx_sw_count != '0);
  assign tx_hold = !tx_pin_sync[1] || (tx_sw_count != '0);

  always_ff @(posedge clock) begin
    if (core_rst) begin
      rx_reset <= 1'b1;
      tx_reset <= 1'b1;
    end else begin
      rx_reset <= rx_hold;
      tx_reset <= tx_hold;
    end
  end

  // Speed in force: register with the port, vector without it
  logic [1:0] speed_now;
  assign speed_now = MGMT_EN ? speed_cfg[SPD_REG_LSB +: 2]
                             : tx_vec_s[SPD_VEC_LSB +: 2];

  always_ff @(posedge clock) begin
    if (core_rst) begin
      speed_flags <= speed_decode(RST_SPEED[SPD_REG_LSB +: 2]);
    end else begin
      speed_flags <= speed_decode(speed_now);
    end
  end

  // Settings in force
  always_ff @(posedge clock) begin
    if (core_rst) begin
      rx_cfg_eff <= '0;
      tx_cfg_eff <= '0;
    end else if (MGMT_EN) begin
      rx_cfg_eff <= RXV_W'(rx_cfg);
      tx_cfg_eff <= TXV_W'(tx_cfg);
    end else begin
      rx_cfg_eff <= rx_vec_s;
      tx_cfg_eff <= tx_vec_s;
    end
  end

  // One registered copy feeds both dividers, in step with the speed flags
  logic [1:0] speed_div;
  always_ff @(posedge clock) begin
    if (core_rst) begin
      speed_div <= RST_SPEED[SPD_REG_LSB +: 2];
    end else begin
      speed_div <= speed_now;
    end
  end

  // Link clock enables; client logic is expected to run off these
  mcr_rate_div u_tx_div (
    .clock(clock),
    .rst(core_rst),
    .hold(tx_reset),
    .speed(speed_div),
    .tick(tx_clk_en)
  );

  mcr_rate_div u_rx_div (
    .clock(clock),
    .rst(core_rst),
    .hold(rx_reset),
    .speed(speed_div),
    .tick(rx_clk_en)
  );

  // Bus answer: fixed one wait state keeps the decode off the critical path
  // Read data and response are registered, so they stand for the whole answer cycle
  logic [31:0] status_word;
  assign status_word = {26'h0, speed_now, tx_reset, rx_reset, speed_flags.low,
                        speed_flags.hundred};

  always_ff @(posedge clock) begin
    if (core_rst) begin
      state <= ST_IDLE;
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
      response <= RESP_OK;
    end else begin
      case (state)
        ST_IDLE: begin
          if (read || write) begin
            state <= ST_ANSWER;
            waitrequest <= 1'b0;
            response <= (sel == REG_NONE || (!MGMT_EN && write)) ? RESP_SLVERR : RESP_OK;
            case (sel)
              REG_RX: readdata <= rx_cfg;
              REG_TX: readdata <= tx_cfg;
              REG_SPD: readdata <= speed_cfg;
              REG_STAT: readdata <= status_word;
              REG_PHY: readdata <= phy_mgmt_word;
              default: readdata <= 32'h00000000;
            endcase
          end
        end
        ST_ANSWER: begin
          state <= ST_IDLE;
          waitrequest <= 1'b1;
        end
        default: begin
          state <= ST_IDLE;
          waitrequest <= 1'b1;
        end
      endcase
    end
  end

endmodule : mcr_top

/* verification/mcr_checker_assertions.sv */
`timescale 1ns/1ps
module mcr_checker
  import mcr_pkg::*;
(
  input wire logic clock, // Clock
  input wire logic rst, // Reset
  input wire logic glbl_rst_n, // Global reset
  input wire logic rx_dom_rst_n, // RX pin
  input wire logic tx_dom_rst_n, // TX pin
  input wire logic read, // Read
  input wire logic write, // Write
  input wire logic waitrequest, // Wait
  input wire logic rx_reset, // RX reset out
  input wire logic tx_reset, // TX reset out
  input wire logic tx_clk_en, // TX enable
  input wire logic rx_clk_en, // RX enable
  input mcr_speed_flags_t speed_flags // Flags
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst || !glbl_rst_n);
  a_wait_one: assert property ($fell(waitrequest) |=> waitrequest)
    else $error("wait low too long");
  a_take_next: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("no answer");
  a_ack_asked: assert property ($fell(waitrequest) |-> $past(read || write))
    else $error("answer unasked");
  a_flag_order: assert property (speed_flags.hundred |-> speed_flags.low)
    else $error("hundred without low");
  a_rx_dom: assert property (!rx_dom_rst_n [*3] |=> rx_reset)
    else $error("rx reset late");
  a_tx_dom: assert property (!tx_dom_rst_n [*3] |=> tx_reset)
    else $error("tx reset late");
  a_rx_gate: assert property (rx_reset && $past(rx_reset) |-> !rx_clk_en)
    else $error("rx enable in reset");
  a_tx_gig: assert property (tx_clk_en && !speed_flags.low |=> !tx_clk_en)
    else $error("tx gig rate");
  a_rx_mid: assert property (rx_clk_en && speed_flags.hundred |=>
    (!rx_clk_en || !$past(speed_flags.hundred)) [*8])
    else $error("rx 100 rate");
  a_swrst_hold: assert property ($rose(rx_reset) && rx_dom_rst_n |=> rx_reset [*8])
    else $error("rx reset short");
  cover property (speed_flags.hundred);
  cover property ($rose(tx_reset));
  cover property (!waitrequest && read);
endmodule : mcr_checker
bind mcr_top mcr_checker u_mcr_checker (.clock, .rst, .glbl_rst_n, .rx_dom_rst_n,
  .tx_dom_rst_n, .read, .write, .waitrequest, .rx_reset, .tx_reset, .tx_clk_en,
  .rx_clk_en, .speed_flags);

/* verification/mcr_host.sv */
`timescale 1ns/1ps
module mcr_host (
  input wire logic clock, // Clock
  input wire logic waitrequest, // Wait
  input wire logic [31:0] readdata, // Read data
  input wire logic [1:0] response, // Response
  output logic [11:0] address, // Address
  output logic read, // Read
  output logic write, // Write
  output logic [31:0] writedata, // Write data
  output logic [3:0] byteenable // Lanes
);
  initial begin
    address = 12'hFFF;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'hF;
  end
  task automatic xfer(input bit w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic [1:0] r, output bit late);
    int n;
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    // Answer and data are taken at the edge that sees waitrequest low
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (waitrequest === 1'b0) break;
    end
    q = readdata;
    r = response;
    late = (n == 40);
    read <= 1'b0;
    write <= 1'b0;
    address <= ~a;
    writedata <= ~d;
  endtask : xfer
endmodule : mcr_host

/* verification/test_mcr_top.sv */
`timescale 1ns/1ps
module test_mcr_top
  import mcr_pkg::*;
;
  logic clock = 0, rst = 1, glbl_rst_n = 1, rx_dom_rst_n = 1, tx_dom_rst_n = 1;
  logic [79:0] rx_vec = '0, tx_vec = '0, rx_eff, tx_eff, rx_eff2, tx_eff2;
  logic [11:0] address;
  logic [31:0] writedata, readdata, phy_word, q;
  logic [3:0] byteenable;
  logic [1:0] response, r;
  logic read, write, waitrequest, go, rx_reset, tx_reset, tx_ce, rx_ce;
  mcr_speed_flags_t flags, flags2;
  int bad_count = 0, num_checks = 0;
  always #2 clock = ~clock;
  mcr_host u_mcr_host (.clock, .waitrequest, .readdata, .response, .address, .read, .write,
    .writedata, .byteenable);
  mcr_top u_mcr_top (.clock, .rst, .glbl_rst_n, .rx_dom_rst_n, .tx_dom_rst_n, .address,
    .read, .write, .writedata, .byteenable, .readdata, .response, .waitrequest,
    .rx_cfg_vec(rx_vec), .tx_cfg_vec(tx_vec), .rx_cfg_eff(rx_eff), .tx_cfg_eff(tx_eff),
    .phy_mgmt_word(phy_word), .phy_mgmt_go(go), .rx_reset, .tx_reset, .tx_clk_en(tx_ce),
    .rx_clk_en(rx_ce), .speed_flags(flags));
  mcr_top #(.MGMT_EN(1'b0)) u_mcr_top_vec (.clock, .rst, .glbl_rst_n, .rx_dom_rst_n,
    .tx_dom_rst_n, .address, .read, .write, .writedata, .byteenable, .readdata(),
    .response(), .waitrequest(), .rx_cfg_vec(rx_vec), .tx_cfg_vec(tx_vec),
    .rx_cfg_eff(rx_eff2), .tx_cfg_eff(tx_eff2), .phy_mgmt_word(), .phy_mgmt_go(),
    .rx_reset(), .tx_reset(), .tx_clk_en(), .rx_clk_en(), .speed_flags(flags2));
  task chk(input logic [79:0] got, input logic [79:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task bus(input bit w, input logic [11:0] a, input logic [31:0] d);
    bit late;
    u_mcr_host.xfer(w, a, d, q, r, late);
    if (late) begin
      bad_count++;
      stop_test;
    end
  endtask : bus
  task period(input bit tx, output int p);
    int n, first;
    first = -1;
    p = 0;
    for (n = 0; n < 400 && p == 0; n++) begin
      @(negedge clock);
      if ((tx ? tx_ce : rx_ce) === 1'b1) begin
        if (first >= 0) p = n - first;
        else first = n;
      end
    end
  endtask : period
  task t_regs;
    bus(0, 12'h000, 0); chk(q, RST_RX_CFG);
    bus(0, 12'h008, 0); chk(q, RST_SPEED);
    bus(0, 12'h010, 0); chk(q, RST_PHY_MGMT);
    chk(flags, 2'b00);
    bus(0, 12'h00C, 0); chk(q, {26'h0, SPD_1G, 4'h0});
    bus(1, 12'h000, 32'h00001234); chk(r, RESP_OK);
    bus(1, 12'h004, 32'h00C0FFEE);
    bus(0, 12'h004, 0); chk(q, 32'h00C0FFEE);
    chk(rx_eff, 80'h1234);
    chk(tx_eff, 80'h00C0FFEE);
    bus(1, 12'h014, 32'h0000FFFF); chk(r, RESP_SLVERR);
    bus(0, 12'h014, 0); chk(r, RESP_SLVERR);
    chk(q, 32'h0);
    $display("regs test done");
  endtask : t_regs
  task t_speed;
    int c, p;
    for (c = 0; c < 4; c++) begin
      bus(1, 12'h008, {c[1:0], 30'h0});
      repeat (4) @(posedge clock);
      chk(flags, {c == 1, c < 2});
      period(1, p); chk(p, c == 0 ? DIV_10 : c == 1 ? DIV_100 : DIV_1G);
      period(0, p); chk(p, c == 0 ? DIV_10 : c == 1 ? DIV_100 : DIV_1G);
    end
    $display("speed test done");
  endtask : t_speed
  task t_resets;
    int n, hi, g;
    hi = 0;
    g = 0;
    bus(1, 12'h000, 32'h80000000);
    for (n = 0; n < 30; n++) begin
      @(negedge clock);
      hi += (rx_reset === 1'b1) + (tx_reset !== 1'b0) * 100;
    end
    chk(hi inside {16, 17}, 1'b1);
    bus(0, 12'h000, 0); chk(q[31], 1'b0);
    bus(1, 12'h010, 32'h5A5A1234);
    for (n = 0; n < 6; n++) begin
      @(negedge clock);
      g += (go === 1'b1);
    end
    chk(g, 1);
    chk(phy_word, 32'h5A5A1234);
    @(posedge clock);
    rx_dom_rst_n <= 1'b0;
    repeat (5) @(posedge clock);
    @(negedge clock);
    chk({rx_reset, tx_reset}, 2'b10);
    @(posedge clock);
    rx_dom_rst_n <= 1'b1;
    bus(1, 12'h008, 32'h40000000);
    glbl_rst_n <= 1'b0;
    repeat (4) @(posedge clock);
    @(negedge clock);
    chk({rx_reset, tx_reset}, 2'b11);
    @(posedge clock);
    glbl_rst_n <= 1'b1;
    // Release needs sync edges before the bus may be used
    repeat (8) @(posedge clock);
    bus(0, 12'h008, 0); chk(q, RST_SPEED);
    $display("reset test done");
  endtask : t_resets
  task t_vec;
    int c;
    for (c = 0; c < 3; c++) begin
      @(posedge clock);
      rx_vec <= {16'hA5C3, 62'h0, c[1:0]};
      tx_vec <= {13'h0, c[1:0], 65'h1_2345_6789_ABCD_EF01};
      repeat (4) @(posedge clock);
      @(negedge clock);
      chk(rx_eff2, rx_vec);
      chk(tx_eff2, tx_vec);
      chk(flags2, {c == 1, c < 2});
    end
    $display("vector test done");
  endtask : t_vec
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_regs;
    t_speed;
    t_resets;
    t_vec;
    stop_test;
  end
endmodule : test_mcr_top
